/* File: src/sbcst_pkg.sv */
// Purpose: shared types and constants of the supply/thermal status bank
// Assumes: one 20 MHz clock, all event sources on that clock
// Notes:   offsets are the 7-bit serial register addresses

package sbcst_pkg;

  // ----------------------------------------------------------------
  // device modes as reported by the mode controller
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_INIT     = 3'h0,
    MODE_NORMAL   = 3'h1,
    MODE_STOP     = 3'h2,
    MODE_SLEEP    = 3'h3,
    MODE_RESTART  = 3'h4,
    MODE_FAILSAFE = 3'h5
  } sbcst_mode_t;

  // short-to-ground detector states
  typedef enum logic [1:0] {
    SC_IDLE   = 2'h0,
    SC_TIMING = 2'h1,
    SC_SHORT  = 2'h2
  } sbcst_sc_state_t;

  // ----------------------------------------------------------------
  // event carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic highside_supply_undervolt;
    logic highside_supply_overvolt;
    logic secondary_reg_overtemp;
    logic secondary_reg_undervolt;
    logic main_reg_undervolt;       // level, below reset threshold
    logic undervolt_failsafe_entry; // pulse, 4th consecutive uv
    logic main_reg_on;              // level, main regulator enabled
  } sbcst_supply_ev_t;

  typedef struct packed {
    logic thermal_shutdown_second;
    logic thermal_shutdown_first;
    logic thermal_prewarning;
  } sbcst_thermal_ev_t;

  typedef struct packed {
    logic restart_fail;   // pulse, restart cause is a failure
    logic restart_sleep;  // pulse, restart cause is sleep
    logic serial_invalid; // pulse, bad serial command seen
    logic fail_output;    // pulse, fail output raised elsewhere
    logic watchdog_failure_count;        // pulse, watchdog trigger failure
    logic wd_trigger_ok;  // pulse, good watchdog trigger
    logic wd_stopped;     // level, watchdog not running
    logic wd_stop_by_fail; // level, stop came from a wd failure
  } sbcst_history_ev_t;

  typedef struct packed {
    logic       valid; // one-cycle command strobe
    logic       clear; // command bit 7
    logic [6:0] addr;  // 7-bit register address
  } sbcst_cmd_t;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_SUPPLY  = 7'h41;
  localparam logic [6:0] ADDR_THERMAL = 7'h42;
  localparam logic [6:0] ADDR_HISTORY = 7'h43;

  localparam logic [7:0] SUPPLY_POR_VAL  = 8'h80;
  localparam logic [7:0] SUPPLY_SOFT_VAL = 8'h00;
  localparam logic [2:0] THERMAL_RST_VAL = 3'h0;
  localparam logic [1:0] HIST_RST_VAL    = 2'h0;

  localparam int BIT_POR       = 7;
  localparam int BIT_MAIN_SC   = 2;
  localparam int BIT_UV_FS     = 1;
  localparam int BIT_MAIN_UV   = 0;
  localparam int BIT_THERMAL_SHUTDOWN_SECOND      = 2;
  localparam int BIT_SER_FAIL  = 1;
  localparam int BIT_FAILURE   = 0;

  localparam logic [1:0] CAUSE_NONE  = 2'h0;
  localparam logic [1:0] CAUSE_FAIL  = 2'h1;
  localparam logic [1:0] CAUSE_SLEEP = 2'h2;

  // watchdog configurations 1..4 encoded 0..3
  localparam logic [1:0] WD_CFG1 = 2'h0;
  localparam logic [1:0] WD_CFG2 = 2'h1;
  localparam logic [1:0] WD_CFG3 = 2'h2;
  localparam logic [1:0] WD_CFG4 = 2'h3;
  localparam logic [1:0] WD_CNT_ZERO  = 2'h0;
  localparam logic [1:0] WD_LIMIT_ONE = 2'h1;
  localparam logic [1:0] WD_LIMIT_TWO = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ  = 20;
  localparam int SHORT_TIME_US = 4000;
  localparam int SHORT_CYC     = SHORT_TIME_US * CLK_FREQ_MHZ;
  localparam int SC_CNT_W      = 17;

endpackage

/* File: src/sbcst_sticky.sv */
// Purpose: row of sticky flags, set by hardware, cleared by command
// Assumes: set, clear and zero are on the module clock
// Notes:   a set in the cycle of a clear survives

`timescale 1ns/100ps

module sbcst_sticky #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // control
  input  wire logic         zero_in,  // soft reset, all to zero
  input  wire logic         clr_in,   // clear command
  input  wire logic [W-1:0] set_in,   // set events
  // state
  output logic      [W-1:0] flags_out
);

  logic [W-1:0] flags_q;

  // set beats clear so no event is dropped
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flags_q <= RST_VAL;
    end else if (zero_in) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~{W{clr_in}}) | set_in;
    end
  end

  assign flags_out = flags_q;

endmodule

/* File: src/sbcst_top.sv */
// Purpose: supply, thermal and device history status bytes
// Assumes: serial frames decoded upstream into one command strobe
// Notes:   read data is the byte as it was before any clear

`timescale 1ns/100ps

module sbcst_top #(
  // short detection window, shorten for simulation
  parameter int SHORT_CYC = sbcst_pkg::SHORT_CYC
) (
  // clock and reset
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_in,
  input  wire logic                          soft_reset_in,
  // mode controller
  input  wire sbcst_pkg::sbcst_mode_t        mode_in,
  input  wire logic                          reset_out_released_in,
  // monitor events
  input  wire sbcst_pkg::sbcst_supply_ev_t   supply_ev_in,
  input  wire sbcst_pkg::sbcst_thermal_ev_t  thermal_ev_in,
  input  wire sbcst_pkg::sbcst_history_ev_t  history_ev_in,
  // watchdog configuration
  input  wire logic                          wd_cfg_bit_in,
  input  wire logic [1:0]                    wd_config_in,
  // serial command port
  input  wire sbcst_pkg::sbcst_cmd_t         cmd_in,
  output logic [7:0]                         rd_data_out,
  output logic                               rd_valid_out,
  output logic                               rd_hit_out,
  // requests to the mode controller
  output logic                               failsafe_req_out,
  output logic                               wd_restart_req_out,
  output logic                               fail_activate_out,
  output logic                               main_reg_short_out
);

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic hit_supply;   // command addresses supply byte
  logic hit_thermal;  // command addresses thermal byte
  logic hit_history;  // command addresses history byte
  logic clr_supply;   // clear strobe per byte
  logic clr_thermal;
  logic clr_history;

  assign hit_supply  = cmd_in.valid &&
                       (cmd_in.addr == sbcst_pkg::ADDR_SUPPLY);
  assign hit_thermal = cmd_in.valid &&
                       (cmd_in.addr == sbcst_pkg::ADDR_THERMAL);
  assign hit_history = cmd_in.valid &&
                       (cmd_in.addr == sbcst_pkg::ADDR_HISTORY);
  // bit 7 set turns the access into read-and-clear
  assign clr_supply  = hit_supply  & cmd_in.clear;
  assign clr_thermal = hit_thermal & cmd_in.clear;
  assign clr_history = hit_history & cmd_in.clear;

  // ----------------------------------------------------------------
  // mode gating
  // ----------------------------------------------------------------
  logic ro_seen_q;    // reset output released once since power-on
  logic reg_off_sleep; // sleep with main regulator off
  logic uv_allow;      // main undervolt may update now

  // remember the first reset release; kept over soft reset
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ro_seen_q <= 1'b0;
    end else if (reset_out_released_in) begin
      ro_seen_q <= 1'b1;
    end
  end

  assign reg_off_sleep = (mode_in == sbcst_pkg::MODE_SLEEP) &&
                         !supply_ev_in.main_reg_on;

  // ----------------------------------------------------------------
  // short-to-ground detector
  // ----------------------------------------------------------------
  sbcst_pkg::sbcst_sc_state_t sc_state_q;
  sbcst_pkg::sbcst_sc_state_t sc_state_d;
  logic [sbcst_pkg::SC_CNT_W-1:0] sc_cnt_q;
  logic [sbcst_pkg::SC_CNT_W-1:0] sc_cnt_d;
  logic sc_low;       // output low while regulator enabled
  logic sc_expired;   // low for longer than the window
  logic sc_present;   // short condition stands

  assign sc_low     = supply_ev_in.main_reg_undervolt &&
                      supply_ev_in.main_reg_on;
  // strictly longer than the window, so compare with >=
  assign sc_expired = (sc_cnt_q >=
                       sbcst_pkg::SC_CNT_W'(SHORT_CYC));
  assign sc_present = (sc_state_q == sbcst_pkg::SC_SHORT);

  // next state: any return above threshold restarts the wait
  always_comb begin
    sc_state_d = sc_state_q;
    sc_cnt_d   = sc_cnt_q;
    case (sc_state_q)
      sbcst_pkg::SC_IDLE: begin
        sc_cnt_d = '0;
        if (sc_low) begin
          sc_state_d = sbcst_pkg::SC_TIMING;
        end
      end
      sbcst_pkg::SC_TIMING: begin
        if (!sc_low) begin
          sc_state_d = sbcst_pkg::SC_IDLE;
          sc_cnt_d   = '0;
        end else if (sc_expired) begin
          sc_state_d = sbcst_pkg::SC_SHORT;
        end else begin
          sc_cnt_d = sc_cnt_q + 1'b1;
        end
      end
      sbcst_pkg::SC_SHORT: begin
        if (!sc_low) begin
          sc_state_d = sbcst_pkg::SC_IDLE;
          sc_cnt_d   = '0;
        end
      end
      default: begin
        sc_state_d = sbcst_pkg::SC_IDLE;
        sc_cnt_d   = '0;
      end
    endcase
  end

  // detector registers
  always_ff @(posedge core_clk_in) begin
    if (rst_in || soft_reset_in) begin
      sc_state_q <= sbcst_pkg::SC_IDLE;
      sc_cnt_q   <= '0;
    end else begin
      sc_state_q <= sc_state_d;
      sc_cnt_q   <= sc_cnt_d;
    end
  end

  // undervolt update window per mode
  always_comb begin
    uv_allow = 1'b0;
    case (mode_in)
      sbcst_pkg::MODE_NORMAL: uv_allow = 1'b1;
      sbcst_pkg::MODE_STOP:   uv_allow = 1'b1;
      sbcst_pkg::MODE_INIT:   uv_allow = ro_seen_q;
      sbcst_pkg::MODE_RESTART: uv_allow = 1'b0;
      default: uv_allow = 1'b0; // sleep, fail-safe: short only
    endcase
    // a standing short opens the window in every mode
    if (sc_present) begin
      uv_allow = 1'b1;
    end
    // regulator off in sleep: nothing meaningful to report
    if (reg_off_sleep) begin
      uv_allow = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // supply status byte
  // ----------------------------------------------------------------
  logic [7:0] supply_set;    // set events in byte order
  logic [7:0] supply_flags;  // stored byte

  // bit order: por, hs uv, hs ov, sec ot, sec uv, sc, uv fs, uv
  always_comb begin
    supply_set = 8'h00;
    supply_set[6] = supply_ev_in.highside_supply_undervolt;
    supply_set[5] = supply_ev_in.highside_supply_overvolt;
    supply_set[4] = supply_ev_in.secondary_reg_overtemp;
    supply_set[3] = supply_ev_in.secondary_reg_undervolt;
    supply_set[sbcst_pkg::BIT_MAIN_SC] =
      sc_present & ~reg_off_sleep;
    supply_set[sbcst_pkg::BIT_UV_FS] =
      supply_ev_in.undervolt_failsafe_entry;
    supply_set[sbcst_pkg::BIT_MAIN_UV] =
      supply_ev_in.main_reg_undervolt & uv_allow;
  end

  // power-on reset loads the por flag, soft reset zeroes it
  sbcst_sticky #(
    .W       (8),
    .RST_VAL (sbcst_pkg::SUPPLY_POR_VAL)
  ) u_supply (
    .clk_in    (core_clk_in),
    .rst_in    (rst_in),
    .zero_in   (soft_reset_in),
    .clr_in    (clr_supply),
    .set_in    (supply_set),
    .flags_out (supply_flags)
  );

  // ----------------------------------------------------------------
  // thermal status byte
  // ----------------------------------------------------------------
  logic [2:0] thermal_set;
  logic [2:0] thermal_flags;

  // flags persist after the temperature falls back
  assign thermal_set = {thermal_ev_in.thermal_shutdown_second,
                        thermal_ev_in.thermal_shutdown_first,
                        thermal_ev_in.thermal_prewarning};

  sbcst_sticky #(
    .W       (3),
    .RST_VAL (sbcst_pkg::THERMAL_RST_VAL)
  ) u_thermal (
    .clk_in    (core_clk_in),
    .rst_in    (rst_in),
    .zero_in   (soft_reset_in),
    .clr_in    (clr_thermal),
    .set_in    (thermal_set),
    .flags_out (thermal_flags)
  );

  // second shutdown forces fail-safe; registered copy of the event, one cycle late
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      failsafe_req_out <= 1'b0;
    end else begin
      failsafe_req_out <= thermal_ev_in.thermal_shutdown_second;
    end
  end

  // ----------------------------------------------------------------
  // device history byte
  // ----------------------------------------------------------------
  logic [1:0] cause_q;       // state before restart
  logic [1:0] wd_count;      // watchdog failure counter
  logic       wd_reach;      // this failure reaches the limit
  logic       watchdog_failure_count_act;   // watchdog wants the fail output
  logic [1:0] hist_set;      // serial fail, failure
  logic [1:0] hist_flags;

  // restart cause; failure wins if both arrive together
  always_ff @(posedge core_clk_in) begin
    if (rst_in || soft_reset_in) begin
      cause_q <= sbcst_pkg::CAUSE_NONE;
    end else if (history_ev_in.restart_fail) begin
      cause_q <= sbcst_pkg::CAUSE_FAIL;
    end else if (history_ev_in.restart_sleep) begin
      cause_q <= sbcst_pkg::CAUSE_SLEEP;
    end else if (clr_history) begin
      cause_q <= sbcst_pkg::CAUSE_NONE;
    end
  end

  // watchdog failure counter, not touched by clear commands
  sbcst_wd_count u_wd (
    .clk_in          (core_clk_in),
    .rst_in          (rst_in),
    .zero_in         (soft_reset_in),
    .fail_in         (history_ev_in.watchdog_failure_count),
    .ok_in           (history_ev_in.wd_trigger_ok),
    .stop_in         (history_ev_in.wd_stopped),
    .stop_by_fail_in (history_ev_in.wd_stop_by_fail),
    .config_in       (wd_config_in),
    .count_out       (wd_count),
    .reach_out       (wd_reach)
  );

  // with cfg bit low the very first failure only restarts
  assign watchdog_failure_count_act = wd_reach &&
                       (wd_cfg_bit_in ||
                        (wd_count != sbcst_pkg::WD_CNT_ZERO));

  assign hist_set[sbcst_pkg::BIT_SER_FAIL] =
    history_ev_in.serial_invalid;
  assign hist_set[sbcst_pkg::BIT_FAILURE] =
    history_ev_in.fail_output | watchdog_failure_count_act;

  sbcst_sticky #(
    .W       (2),
    .RST_VAL (sbcst_pkg::HIST_RST_VAL)
  ) u_hist (
    .clk_in    (core_clk_in),
    .rst_in    (rst_in),
    .zero_in   (soft_reset_in),
    .clr_in    (clr_history),
    .set_in    (hist_set),
    .flags_out (hist_flags)
  );

  // watchdog outcome pulses toward the mode controller
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wd_restart_req_out <= 1'b0;
      fail_activate_out  <= 1'b0;
    end else begin
      wd_restart_req_out <= history_ev_in.watchdog_failure_count;
      fail_activate_out  <= watchdog_failure_count_act;
    end
  end

  // registered copy of the short condition
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      main_reg_short_out <= 1'b0;
    end else begin
      main_reg_short_out <= sc_present;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;  // byte selected by the command

  // reserved positions are tied low in the assembly
  always_comb begin
    rd_mux = 8'h00;
    if (hit_supply) begin
      rd_mux = supply_flags;
    end else if (hit_thermal) begin
      rd_mux = {5'h00, thermal_flags};
    end else if (hit_history) begin
      rd_mux = {cause_q, 2'h0, wd_count, hist_flags};
    end
  end

  // answer one cycle after the strobe; old value before clear
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rd_data_out  <= 8'h00;
      rd_valid_out <= 1'b0;
      rd_hit_out   <= 1'b0;
    end else begin
      rd_data_out  <= rd_mux;
      rd_valid_out <= cmd_in.valid;
      rd_hit_out   <= hit_supply | hit_thermal | hit_history;
    end
  end

endmodule

/* File: src/sbcst_wd_count.sv */
// Purpose: watchdog failure counter, saturating below 11
// Assumes: event pulses come from the watchdog on this clock
// Notes:   a failure that bumps the count beats a clear arriving in the same cycle

`timescale 1ns/100ps

module sbcst_wd_count (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // watchdog events
  input  wire logic       zero_in,
  input  wire logic       fail_in,
  input  wire logic       ok_in,
  input  wire logic       stop_in,
  input  wire logic       stop_by_fail_in,
  input  wire logic [1:0] config_in,
  // state
  output logic      [1:0] count_out,
  output logic            reach_out   // this failure hits the limit
);

  logic [1:0] count_q;
  logic       frozen_q;
  logic [1:0] limit;
  logic       bump;

  // config 2 sets the limit at one failure, the others at two
  assign limit = (config_in == sbcst_pkg::WD_CFG2) ?
                 sbcst_pkg::WD_LIMIT_ONE : sbcst_pkg::WD_LIMIT_TWO;
  assign bump      = fail_in & ~frozen_q & (count_q < limit);
  assign reach_out = bump & ((count_q + 2'h1) == limit);

  // counter, cleared on good trigger or a plain watchdog stop
  always_ff @(posedge clk_in) begin
    if (rst_in || zero_in) begin
      count_q <= sbcst_pkg::WD_CNT_ZERO;
    end else if (bump) begin
      count_q <= count_q + 2'h1;
    end else if (ok_in || (stop_in && !stop_by_fail_in)) begin
      count_q <= sbcst_pkg::WD_CNT_ZERO;
    end
  end

  // configs 2 and 4 hold the count until a good trigger
  always_ff @(posedge clk_in) begin
    if (rst_in || zero_in) begin
      frozen_q <= 1'b0;
    end else if (fail_in && (config_in == sbcst_pkg::WD_CFG2 ||
                             config_in == sbcst_pkg::WD_CFG4)) begin
      frozen_q <= 1'b1;
    end else if (ok_in) begin
      frozen_q <= 1'b0;
    end
  end

  assign count_out = count_q;

endmodule

/* File: tb/sbcst_host.sv */
// Purpose: host side issuing read and clear commands
// Assumes: answer arrives on the registered read strobe
// Notes:   idle command lines carry inverted leftovers
`timescale 1ns/100ps
module sbcst_host (
  // clock
  input  wire logic             clk_in,
  // answer from the bank
  input  wire logic [7:0]       rd_data_in,
  input  wire logic             rd_valid_in,
  input  wire logic             rd_hit_in,
  // command to the bank
  output sbcst_pkg::sbcst_cmd_t cmd_out
);
  initial cmd_out = '0; // quiet at time zero
  // one command: strobe for one edge, then a bounded wait
  task automatic xfer(input logic c, input logic [6:0] a,
                      output logic [7:0] d, output logic h,
                      output bit ok);
    ok = 1'b0;
    d = 8'h00;
    h = 1'b0;
    @(posedge clk_in);
    cmd_out <= '{valid: 1'b1, clear: c, addr: a};
    @(posedge clk_in);
    // idle lines never keep a clean copy of the last command
    cmd_out <= '{valid: 1'b0, clear: ~c, addr: ~a};
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk_in);
      if (rd_valid_in === 1'b1) begin
        d = rd_data_in;
        h = rd_hit_in;
        ok = 1'b1;
      end
    end
  endtask
endmodule

/* File: tb/sbcst_properties.sv */
// Purpose: port-level timing checks for the status bank
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound onto the top from the bench file
`timescale 1ns/100ps
module sbcst_properties (
  // clock and reset
  input wire logic                         core_clk_in,
  input wire logic                         rst_in,
  input wire logic                         soft_reset_in,
  // events and command
  input wire sbcst_pkg::sbcst_supply_ev_t  supply_ev_in,
  input wire sbcst_pkg::sbcst_thermal_ev_t thermal_ev_in,
  input wire sbcst_pkg::sbcst_history_ev_t history_ev_in,
  input wire sbcst_pkg::sbcst_cmd_t        cmd_in,
  // answers and requests
  input wire logic [7:0]                   rd_data_out,
  input wire logic                         rd_valid_out,
  input wire logic                         rd_hit_out,
  input wire logic                         failsafe_req_out,
  input wire logic                         wd_restart_req_out,
  input wire logic                         fail_activate_out,
  input wire logic                         main_reg_short_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  // ----------
  // address decode
  // ----------
  wire logic [6:0] a   = cmd_in.addr; // command address
  wire logic       sup = cmd_in.valid && a == sbcst_pkg::ADDR_SUPPLY;
  wire logic       thm = cmd_in.valid && a == sbcst_pkg::ADDR_THERMAL;
  wire logic       his = cmd_in.valid && a == sbcst_pkg::ADDR_HISTORY;
  wire logic       ump = cmd_in.valid && !(sup || thm || his); // no byte
  // ----------
  // checks
  // ----------
  answer_pulse_a: assert property (cmd_in.valid |=> rd_valid_out)
    else $error("command not answered");
  idle_quiet_a: assert property (
    !cmd_in.valid |=> !rd_valid_out && rd_data_out == 8'h00)
    else $error("answer without command");
  unmapped_empty_a: assert property (
    ump |=> !rd_hit_out && rd_data_out == 8'h00)
    else $error("unmapped address answered");
  therm_reserved_a: assert property (
    thm |=> rd_hit_out && rd_data_out[7:3] == 5'h00)
    else $error("thermal reserved bits set");
  hist_reserved_a: assert property (
    his |=> rd_data_out[5:4] == 2'h0 && rd_data_out[3:2] != 2'h3)
    else $error("history reserved or count bad");
  thermal_shutdown_second_request_a: assert property (
    thermal_ev_in.thermal_shutdown_second |=> failsafe_req_out)
    else $error("no failsafe request");
  wd_restart_a: assert property (
    history_ev_in.watchdog_failure_count |=> wd_restart_req_out)
    else $error("no restart request");
  fail_cause_a: assert property (
    fail_activate_out |-> $past(history_ev_in.watchdog_failure_count))
    else $error("fail output without cause");
  // soft reset gets no say in the window, it would zero the byte
  prewarn_kept_a: assert property (
    (thermal_ev_in.thermal_prewarning && !soft_reset_in) ##1
    (thm && !soft_reset_in) |=> rd_data_out[0])
    else $error("prewarning flag lost");
  soft_zero_a: assert property (
    soft_reset_in ##1 sup |=> rd_data_out == sbcst_pkg::SUPPLY_SOFT_VAL)
    else $error("supply byte not zero after soft reset");
  // short output lags the low regulator sample by two edges
  short_source_a: assert property (
    main_reg_short_out |-> $past(supply_ev_in.main_reg_undervolt &&
                                 supply_ev_in.main_reg_on, 2))
    else $error("short reported without low regulator");
  cover property (thm && cmd_in.clear);
  cover property (fail_activate_out);
  cover property (soft_reset_in ##1 sup);
endmodule

/* File: tb/sbcst_top_tb.sv */
// Purpose: directed checks of the three status bytes
// Assumes: short window cut to a few cycles
// Notes:   each byte check clears it unless told otherwise
`timescale 1ns/100ps
module sbcst_top_tb;
  localparam int SC = 20; // short window, kept small for run time
  logic                         core_clk_in = 1'b0;
  logic                         rst_in = 1'b1;
  logic                         soft_reset_in = 1'b0;
  logic                         reset_out_released_in = 1'b0;
  logic                         wd_cfg_bit_in = 1'b1;
  logic [1:0]                   wd_config_in = 2'h0;
  sbcst_pkg::sbcst_mode_t       mode_in = sbcst_pkg::MODE_NORMAL;
  sbcst_pkg::sbcst_supply_ev_t  supply_ev_in = '0;
  sbcst_pkg::sbcst_thermal_ev_t thermal_ev_in = '0;
  sbcst_pkg::sbcst_history_ev_t history_ev_in = '0;
  sbcst_pkg::sbcst_cmd_t        cmd_in;
  logic [7:0]                   rd_data_out;
  logic                         rd_valid_out;
  logic                         rd_hit_out;
  int                           err_total = 0;
  int                           n_tests = 0;
  always #25 core_clk_in = ~core_clk_in;
  sbcst_top #(.SHORT_CYC(SC)) DUT (.core_clk_in, .rst_in, .soft_reset_in,
    .mode_in, .reset_out_released_in, .supply_ev_in, .thermal_ev_in,
    .history_ev_in, .wd_cfg_bit_in, .wd_config_in, .cmd_in, .rd_data_out,
    .rd_valid_out, .rd_hit_out, .failsafe_req_out(),
    .wd_restart_req_out(), .fail_activate_out(), .main_reg_short_out());
  sbcst_host host (.clk_in(core_clk_in), .rd_data_in(rd_data_out),
    .rd_valid_in(rd_valid_out), .rd_hit_in(rd_hit_out), .cmd_out(cmd_in));
  // ----------
  // tasks
  // ----------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // read (c=0) or read-and-clear (c=1) one byte, compare the answer
  task automatic chk(input logic c, input logic [6:0] a,
                     input logic [7:0] e, input logic eh = 1'b1);
    logic [7:0] d;
    logic       h;
    bit         ok;
    host.xfer(c, a, d, h, ok);
    n_tests++;
    if (!ok) begin
      err_total++;
      end_sim();
    end else if (d !== e || h !== eh) begin
      err_total++;
      $display("BAD t=%0t addr %h got %h want %h", $time, a, d, e);
    end
  endtask
  // one-cycle event pulse on the three event buses
  task automatic ev(input logic [6:0] s, input logic [2:0] t,
                    input logic [7:0] h);
    @(posedge core_clk_in);
    supply_ev_in <= s;
    thermal_ev_in <= t;
    history_ev_in <= h;
    @(posedge core_clk_in);
    supply_ev_in <= '0;
    thermal_ev_in <= '0;
    history_ev_in <= '0;
  endtask
  // hold main undervolt in mode m for n cycles, then check and clear
  task automatic uv(input sbcst_pkg::sbcst_mode_t m, input logic [6:0] s,
                    input int n, input logic [7:0] e);
    @(posedge core_clk_in);
    mode_in <= m;
    supply_ev_in <= s;
    repeat (n) @(posedge core_clk_in);
    supply_ev_in <= '0;
    mode_in <= sbcst_pkg::MODE_NORMAL;
    chk(1, 7'h41, e);
  endtask
  // ----------
  // main sequence
  // ----------
  initial begin
    repeat (12) @(posedge core_clk_in);
    rst_in <= 1'b0;
    chk(0, 7'h41, 8'h80);
    chk(0, 7'h42, 8'h00);
    chk(0, 7'h43, 8'h00);
    chk(1, 7'h44, 8'h00, 1'b0);
    chk(1, 7'h41, 8'h80);
    chk(0, 7'h41, 8'h00);
    for (int i = 1; i < 7; i++) begin
      if (i != 2) begin
        ev(7'(1 << i), 3'h0, 8'h00);
        chk(1, 7'h41, 8'(1 << i));
      end
    end
    fork
      ev(7'h00, 3'h7, 8'h00);
      @(posedge core_clk_in) chk(0, 7'h42, 8'h07);
    join
    chk(1, 7'h42, 8'h07);
    fork
      ev(7'h00, 3'h2, 8'h00);
      chk(1, 7'h42, 8'h00);
    join
    chk(1, 7'h42, 8'h02);
    uv(sbcst_pkg::MODE_INIT, 7'h05, 3, 8'h00);
    uv(sbcst_pkg::MODE_RESTART, 7'h05, 3, 8'h00);
    uv(sbcst_pkg::MODE_NORMAL, 7'h05, 3, 8'h01);
    uv(sbcst_pkg::MODE_STOP, 7'h05, 3, 8'h01);
    uv(sbcst_pkg::MODE_SLEEP, 7'h04, SC + 4, 8'h00);
    uv(sbcst_pkg::MODE_FAILSAFE, 7'h05, 3, 8'h00);
    uv(sbcst_pkg::MODE_RESTART, 7'h05, SC + 4, 8'h05);
    reset_out_released_in <= 1'b1;
    uv(sbcst_pkg::MODE_INIT, 7'h05, 3, 8'h01);
    ev(7'h00, 3'h0, 8'h80);
    chk(1, 7'h43, 8'h40);
    ev(7'h00, 3'h0, 8'h40);
    chk(1, 7'h43, 8'h80);
    ev(7'h00, 3'h0, 8'h20);
    chk(0, 7'h43, 8'h02);
    chk(1, 7'h43, 8'h02);
    ev(7'h00, 3'h0, 8'h10);
    chk(1, 7'h43, 8'h01);
    ev(7'h00, 3'h0, 8'h08);
    chk(0, 7'h43, 8'h04);
    ev(7'h00, 3'h0, 8'h08);
    chk(1, 7'h43, 8'h09);
    ev(7'h00, 3'h0, 8'h04);
    chk(0, 7'h43, 8'h00);
    ev(7'h00, 3'h0, 8'h08);
    ev(7'h00, 3'h0, 8'h03);
    chk(0, 7'h43, 8'h04);
    ev(7'h00, 3'h0, 8'h02);
    chk(0, 7'h43, 8'h00);
    wd_config_in <= 2'h3;
    ev(7'h00, 3'h0, 8'h08);
    ev(7'h00, 3'h0, 8'h08);
    chk(0, 7'h43, 8'h04);
    ev(7'h00, 3'h0, 8'h04);
    wd_config_in <= 2'h1;
    wd_cfg_bit_in <= 1'b0;
    ev(7'h00, 3'h0, 8'h08);
    chk(1, 7'h43, 8'h04);
    ev(7'h00, 3'h0, 8'h24);
    @(posedge core_clk_in);
    soft_reset_in <= 1'b1;
    fork
      chk(0, 7'h41, 8'h00);
      @(posedge core_clk_in) soft_reset_in <= 1'b0;
    join
    chk(0, 7'h43, 8'h00);
    uv(sbcst_pkg::MODE_INIT, 7'h05, 3, 8'h01);
    end_sim();
  end
endmodule
bind sbcst_top sbcst_properties u_props (.core_clk_in, .rst_in,
  .soft_reset_in, .supply_ev_in, .thermal_ev_in, .history_ev_in, .cmd_in,
  .rd_data_out, .rd_valid_out, .rd_hit_out, .failsafe_req_out,
  .wd_restart_req_out, .fail_activate_out, .main_reg_short_out);
